// file: core/atp_pkg.sv
// constants for the test pattern and clock configuration register slice
// Summary of operation
// R01 - a fuse load applies the bit mapping for the current interface
// R02 - host writes the load bit to one, then zero, to take effect
// R03 - load clears earlier configuration writes; program mode and load first
// R04 - constant mode outputs the 18-bit pattern value, top bit at the MSB
// R05 - host writes ramp increment 00001 for 18-bit, 00100 for 16-bit
// R06 - channel B select sits in bits 7 to 5, steers channel B only
// R07 - channel A select sits in bits 4 to 2, steers channel A only
// R08 - codes 000 normal, 010 ramp, 011 constant; other codes unused
// R09 - pattern inserted before the bit mapper, MSB aligned, in every format
// R10 - data clock input enable at bit 4, resets to one, powers buffer
// R11 - host also sets the companion data clock enable in another register
// R12 - host rewrites the data clock enable register after each mode change
// R13 - ramp advances by the increment each sample, wrapping at full width
package atp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned PAT_W  = 18;
  localparam int unsigned SEL_W  = 3;

  localparam logic [ADDR_W-1:0] FUSE_LOAD_OFS  = 8'h13;
  localparam logic [ADDR_W-1:0] PAT_LOW_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] PAT_MID_OFS    = 8'h15;
  localparam logic [ADDR_W-1:0] PAT_HIGH_OFS   = 8'h16;
  localparam logic [ADDR_W-1:0] DCLK_CTRL_OFS  = 8'h18;
  localparam logic [ADDR_W-1:0] FCLK_CTRL_OFS  = 8'h19;

  localparam int unsigned FUSE_LOAD_BIT  = 0;
  localparam int unsigned CHAN_B_SEL_LSB = 5;
  localparam int unsigned CHAN_A_SEL_LSB = 2;
  localparam int unsigned PAT_HIGH_W     = 2;
  localparam int unsigned DCLK_EN_BIT    = 4;
  localparam int unsigned FRAME_CLOCK_SOURCE_BIT   = 7;
  localparam int unsigned FRAME_CLOCK_DIVIDE_BIT   = 4;
  localparam int unsigned FRAME_CLOCK_OUTPUT_ENABLE_BIT    = 1;
  localparam int unsigned FCLK_TOG_BIT   = 0;

  localparam logic [PAT_W-1:0] PAT_RESET     = 18'h00000;
  localparam logic [SEL_W-1:0] SEL_RESET     = 3'h0;
  localparam logic             DCLK_EN_RESET = 1'h1;
  localparam logic             FRAME_CLOCK_SOURCE_RST  = 1'h0;
  localparam logic             FRAME_CLOCK_DIVIDE_RST  = 1'h0;
  localparam logic             FRAME_CLOCK_OUTPUT_ENABLE_RST   = 1'h1;
  localparam logic             FCLK_TOG_RST  = 1'h0;

  localparam logic [SEL_W-1:0] SEL_NORMAL   = 3'h0;
  localparam logic [SEL_W-1:0] SEL_RAMP     = 3'h2;
  localparam logic [SEL_W-1:0] SEL_CONSTANT = 3'h3;
endpackage : atp_pkg

// file: core/atp_fuse_loader.sv
// detects the one-then-zero load sequence and latches the bit mapping
module atp_fuse_loader
  import atp_pkg::*;
#(
  parameter int unsigned IF_W = 2
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            load_bit,
  input  wire logic [IF_W-1:0] iface_mode,
  output logic                 load_pulse,
  output logic [IF_W-1:0]      map_sel
);
  logic            load_bit_d_r;
  logic            load_pulse_r;
  logic [IF_W-1:0] map_sel_r;
  wire             load_fall = load_bit_d_r & ~load_bit;

  // R02 falling edge completes load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_bit_d_r <= 1'b0;
      load_pulse_r <= 1'b0;
    end else begin
      load_bit_d_r <= load_bit;
      load_pulse_r <= load_fall;
    end
  end

  // R01 mapping follows interface mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map_sel_r <= '0;
    end else if (load_fall) begin
      map_sel_r <= iface_mode;
    end
  end

  assign load_pulse = load_pulse_r;
  assign map_sel    = map_sel_r;

  property p_load_maps;
    @(posedge clk) disable iff (!rst_b)
      load_fall |=> (load_pulse && map_sel == $past(iface_mode));
  endproperty
  a_load_maps: assert property (p_load_maps) // R01
    else $error("mapping not loaded on load sequence");

  property p_load_needs_seq;
    @(posedge clk) disable iff (!rst_b)
      load_pulse |-> ($past(load_bit, 2) && !$past(load_bit));
  endproperty
  a_load_needs_seq: assert property (p_load_needs_seq) // R02
    else $error("load pulse without one-then-zero sequence");
endmodule : atp_fuse_loader

// file: core/atp_pattern_chan.sv
// per-channel test pattern insertion ahead of the bit mapper
module atp_pattern_chan
  import atp_pkg::*;
#(
  parameter int unsigned DATA_W = PAT_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [SEL_W-1:0]  pat_sel,
  input  wire logic [PAT_W-1:0]  pat_value,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] conv_data,
  output logic [DATA_W-1:0]      out_data
);
  logic [DATA_W-1:0] ramp_r;
  logic [DATA_W-1:0] out_r;
  logic [DATA_W-1:0] ramp_nxt;
  logic [DATA_W-1:0] out_nxt;
  logic [DATA_W-1:0] pat_aligned;
  wire               is_ramp  = (pat_sel == SEL_RAMP);
  wire               is_const = (pat_sel == SEL_CONSTANT);

  // R04 pattern MSB at output MSB
  assign pat_aligned = (DATA_W >= PAT_W) ?
    DATA_W'({pat_value, {(DATA_W - PAT_W + 1){1'b0}}} >> 1) :
    DATA_W'(pat_value >> (PAT_W - DATA_W));
  // R13 wraps modulo native width
  assign ramp_nxt = is_ramp ? DATA_W'(ramp_r + DATA_W'(pat_value)) : '0;
  // R08 unused codes pass conversion data
  assign out_nxt = is_const ? pat_aligned :
                   is_ramp  ? ramp_r : conv_data;

  // R09 inserted at native resolution
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_r <= '0;
      out_r  <= '0;
    end else if (sample_valid) begin
      ramp_r <= ramp_nxt;
      out_r  <= out_nxt;
    end
  end

  assign out_data = out_r;

  property p_const_out;
    @(posedge clk) disable iff (!rst_b)
      (sample_valid && is_const) |=> (out_data == $past(pat_aligned));
  endproperty
  a_const_out: assert property (p_const_out) // R04
    else $error("constant pattern not driven");

  property p_ramp_step;
    @(posedge clk) disable iff (!rst_b)
      (sample_valid && is_ramp) |=>
        (ramp_r == DATA_W'(out_data + DATA_W'($past(pat_value))));
  endproperty
  a_ramp_step: assert property (p_ramp_step) // R13
    else $error("ramp did not advance by increment");

  property p_normal_pass;
    @(posedge clk) disable iff (!rst_b)
      (sample_valid && !is_ramp && !is_const) |=>
        (out_data == $past(conv_data));
  endproperty
  a_normal_pass: assert property (p_normal_pass) // R08
    else $error("normal or unused code altered data");

  property p_hold_idle;
    @(posedge clk) disable iff (!rst_b)
      !sample_valid |=> $stable(out_data);
  endproperty
  a_hold_idle: assert property (p_hold_idle) // R09
    else $error("output changed without a sample");
endmodule : atp_pattern_chan

// file: core/atp_config_regs.sv
// register slice: fuse load, test patterns, data and frame clock control
module atp_config_regs
  import atp_pkg::*;
#(
  parameter int unsigned DATA_W = PAT_W,
  parameter int unsigned IF_W   = 2
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [REG_W-1:0]  reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [REG_W-1:0]       reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic [IF_W-1:0]   iface_mode,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] chan_a_conv,
  input  wire logic [DATA_W-1:0] chan_b_conv,
  output logic [DATA_W-1:0]      chan_a_data,
  output logic [DATA_W-1:0]      chan_b_data,
  output logic                   fuse_map_load,
  output logic [IF_W-1:0]        bit_map_sel,
  output logic                   data_clock_input_buf_en,
  output logic                   frame_clock_source,
  output logic                   frame_clock_divide,
  output logic                   frame_clock_output_enable,
  output logic                   frame_clock_stretch
);
  logic             fuse_load_r;
  logic [PAT_W-1:0] custom_pattern_value_r;
  logic [SEL_W-1:0] chan_a_pattern_select_r;
  logic [SEL_W-1:0] chan_b_pattern_select_r;
  logic             data_clock_input_enable_r;
  logic             frame_clock_source_r;
  logic             frame_clock_divide_r;
  logic             frame_clock_output_enable_r;
  logic             frame_clock_stretch_r;
  logic [REG_W-1:0] reg_rdata_r;
  logic             reg_rvalid_r;
  logic [REG_W-1:0] rdata_nxt;
  logic             load_pulse;

  wire wr_fuse = reg_wr && (reg_addr == FUSE_LOAD_OFS);
  wire wr_low  = reg_wr && (reg_addr == PAT_LOW_OFS);
  wire wr_mid  = reg_wr && (reg_addr == PAT_MID_OFS);
  wire wr_high = reg_wr && (reg_addr == PAT_HIGH_OFS);
  wire wr_dclk = reg_wr && (reg_addr == DCLK_CTRL_OFS);
  wire wr_fclk = reg_wr && (reg_addr == FCLK_CTRL_OFS);

  function automatic logic [REG_W-1:0] bit_at(input logic v,
                                              input int unsigned pos);
    bit_at = REG_W'(v) << pos;
  endfunction : bit_at

  wire [REG_W-1:0] high_rd =
    REG_W'({chan_b_pattern_select_r, chan_a_pattern_select_r,
            custom_pattern_value_r[PAT_W-1 -: PAT_HIGH_W]});
  wire [REG_W-1:0] fclk_rd =
    bit_at(frame_clock_source_r, FRAME_CLOCK_SOURCE_BIT) |
    bit_at(frame_clock_divide_r, FRAME_CLOCK_DIVIDE_BIT) |
    bit_at(frame_clock_output_enable_r, FRAME_CLOCK_OUTPUT_ENABLE_BIT) |
    bit_at(frame_clock_stretch_r, FCLK_TOG_BIT);

  // reserved bits read as zero; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr)
      FUSE_LOAD_OFS: rdata_nxt = bit_at(fuse_load_r, FUSE_LOAD_BIT);
      PAT_LOW_OFS:   rdata_nxt = custom_pattern_value_r[REG_W-1:0];
      PAT_MID_OFS:   rdata_nxt = custom_pattern_value_r[2*REG_W-1:REG_W];
      PAT_HIGH_OFS:  rdata_nxt = high_rd;
      DCLK_CTRL_OFS: rdata_nxt = bit_at(data_clock_input_enable_r,
                                        DCLK_EN_BIT);
      FCLK_CTRL_OFS: rdata_nxt = fclk_rd;
      default:       rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r  <= '0;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  // load bit itself is kept so the host can write it back to zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_load_r <= 1'b0;
    end else if (wr_fuse) begin
      fuse_load_r <= reg_wdata[FUSE_LOAD_BIT];
    end
  end

  atp_fuse_loader #(
    .IF_W       (IF_W)
  ) u_loader (
    .clk        (clk),
    .rst_b      (rst_b),
    .load_bit   (fuse_load_r),
    .iface_mode (iface_mode),
    .load_pulse (load_pulse),
    .map_sel    (bit_map_sel)
  );

  // R03 load clears earlier writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      custom_pattern_value_r  <= PAT_RESET;
      chan_a_pattern_select_r <= SEL_RESET;
      chan_b_pattern_select_r <= SEL_RESET;
    end else if (load_pulse) begin
      custom_pattern_value_r  <= PAT_RESET;
      chan_a_pattern_select_r <= SEL_RESET;
      chan_b_pattern_select_r <= SEL_RESET;
    end else begin
      if (wr_low) begin
        custom_pattern_value_r[REG_W-1:0] <= reg_wdata;
      end
      if (wr_mid) begin
        custom_pattern_value_r[2*REG_W-1:REG_W] <= reg_wdata;
      end
      // R06 R07 select field placement
      if (wr_high) begin
        custom_pattern_value_r[PAT_W-1 -: PAT_HIGH_W] <=
          reg_wdata[PAT_HIGH_W-1:0];
        chan_a_pattern_select_r <= reg_wdata[CHAN_A_SEL_LSB +: SEL_W];
        chan_b_pattern_select_r <= reg_wdata[CHAN_B_SEL_LSB +: SEL_W];
      end
    end
  end

  // R10 buffer enable, resets to one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_clock_input_enable_r <= DCLK_EN_RESET;
    end else if (load_pulse) begin
      data_clock_input_enable_r <= DCLK_EN_RESET;
    end else if (wr_dclk) begin
      data_clock_input_enable_r <= reg_wdata[DCLK_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_clock_source_r        <= FRAME_CLOCK_SOURCE_RST;
      frame_clock_divide_r        <= FRAME_CLOCK_DIVIDE_RST;
      frame_clock_output_enable_r <= FRAME_CLOCK_OUTPUT_ENABLE_RST;
      frame_clock_stretch_r       <= FCLK_TOG_RST;
    end else if (load_pulse) begin
      frame_clock_source_r        <= FRAME_CLOCK_SOURCE_RST;
      frame_clock_divide_r        <= FRAME_CLOCK_DIVIDE_RST;
      frame_clock_output_enable_r <= FRAME_CLOCK_OUTPUT_ENABLE_RST;
      frame_clock_stretch_r       <= FCLK_TOG_RST;
    end else if (wr_fclk) begin
      frame_clock_source_r        <= reg_wdata[FRAME_CLOCK_SOURCE_BIT];
      frame_clock_divide_r        <= reg_wdata[FRAME_CLOCK_DIVIDE_BIT];
      frame_clock_output_enable_r <= reg_wdata[FRAME_CLOCK_OUTPUT_ENABLE_BIT];
      frame_clock_stretch_r       <= reg_wdata[FCLK_TOG_BIT];
    end
  end

  // R07 channel A path
  atp_pattern_chan #(
    .DATA_W       (DATA_W)
  ) u_chan_a (
    .clk          (clk),
    .rst_b        (rst_b),
    .pat_sel      (chan_a_pattern_select_r),
    .pat_value    (custom_pattern_value_r),
    .sample_valid (sample_valid),
    .conv_data    (chan_a_conv),
    .out_data     (chan_a_data)
  );

  // R06 channel B path
  atp_pattern_chan #(
    .DATA_W       (DATA_W)
  ) u_chan_b (
    .clk          (clk),
    .rst_b        (rst_b),
    .pat_sel      (chan_b_pattern_select_r),
    .pat_value    (custom_pattern_value_r),
    .sample_valid (sample_valid),
    .conv_data    (chan_b_conv),
    .out_data     (chan_b_data)
  );

  assign reg_rdata                 = reg_rdata_r;
  assign reg_rvalid                = reg_rvalid_r;
  assign fuse_map_load             = load_pulse;
  assign data_clock_input_buf_en   = data_clock_input_enable_r;
  assign frame_clock_source        = frame_clock_source_r;
  assign frame_clock_divide        = frame_clock_divide_r;
  assign frame_clock_output_enable = frame_clock_output_enable_r;
  assign frame_clock_stretch       = frame_clock_stretch_r;

  property p_load_clears;
    @(posedge clk) disable iff (!rst_b)
      load_pulse |=> (custom_pattern_value_r == PAT_RESET &&
                      chan_a_pattern_select_r == SEL_RESET &&
                      chan_b_pattern_select_r == SEL_RESET &&
                      data_clock_input_buf_en == DCLK_EN_RESET &&
                      frame_clock_output_enable == FRAME_CLOCK_OUTPUT_ENABLE_RST);
  endproperty
  a_load_clears: assert property (p_load_clears) // R03
    else $error("load did not clear configuration");

  property p_sel_b_field;
    @(posedge clk) disable iff (!rst_b)
      (wr_high && !load_pulse) |=> (chan_b_pattern_select_r ==
        $past(reg_wdata[CHAN_B_SEL_LSB +: SEL_W]));
  endproperty
  a_sel_b_field: assert property (p_sel_b_field) // R06
    else $error("channel B select field misplaced");

  property p_sel_a_field;
    @(posedge clk) disable iff (!rst_b)
      (wr_high && !load_pulse) |=> (chan_a_pattern_select_r ==
        $past(reg_wdata[CHAN_A_SEL_LSB +: SEL_W]));
  endproperty
  a_sel_a_field: assert property (p_sel_a_field) // R07
    else $error("channel A select field misplaced");

  property p_dclk_en;
    @(posedge clk) disable iff (!rst_b)
      ((wr_dclk && !load_pulse) |=>
        (data_clock_input_buf_en == $past(reg_wdata[DCLK_EN_BIT]))) and
      ((reg_rd && reg_addr == DCLK_CTRL_OFS) |=>
        (reg_rdata[DCLK_EN_BIT] == $past(data_clock_input_buf_en)));
  endproperty
  a_dclk_en: assert property (p_dclk_en) // R10
    else $error("data clock enable not taken from bit 4");

  property p_pat_low;
    @(posedge clk) disable iff (!rst_b)
      (wr_low && !load_pulse) |=>
        (custom_pattern_value_r[REG_W-1:0] == $past(reg_wdata));
  endproperty
  a_pat_low: assert property (p_pat_low) // R04
    else $error("pattern low byte not stored");

  property p_pat_mid;
    @(posedge clk) disable iff (!rst_b)
      (wr_mid && !load_pulse) |=>
        (custom_pattern_value_r[2*REG_W-1:REG_W] == $past(reg_wdata));
  endproperty
  a_pat_mid: assert property (p_pat_mid) // R04
    else $error("pattern middle byte not stored");

  // the load bit survives its own load so the host sees what it wrote
  property p_fuse_kept;
    @(posedge clk) disable iff (!rst_b)
      (load_pulse && !wr_fuse) |=> (fuse_load_r == $past(fuse_load_r));
  endproperty
  a_fuse_kept: assert property (p_fuse_kept) // R03
    else $error("load bit disturbed by the load");

  property p_sel_read;
    @(posedge clk) disable iff (!rst_b)
      (reg_rd && reg_addr == PAT_HIGH_OFS) |=>
        (reg_rdata[CHAN_B_SEL_LSB +: SEL_W] ==
           $past(chan_b_pattern_select_r) &&
         reg_rdata[CHAN_A_SEL_LSB +: SEL_W] ==
           $past(chan_a_pattern_select_r));
  endproperty
  a_sel_read: assert property (p_sel_read) // R06
    else $error("select fields read back from wrong bits");
endmodule : atp_config_regs

// file: dv/atp_host_model.sv
// host controller model driving the parallel register port of the slice
module atp_host_model
  import atp_pkg::*;
(
  input  wire logic         clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [REG_W-1:0]  reg_wdata,
  output logic              reg_wr,
  output logic              reg_rd,
  input  wire logic [REG_W-1:0] reg_rdata,
  input  wire logic         reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [REG_W-1:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [REG_W-1:0] d, output bit ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask : rd_reg

  // one then zero, done first in a sequence
  task automatic load_map();
    wr_reg(FUSE_LOAD_OFS, 8'h01);
    wr_reg(FUSE_LOAD_OFS, 8'h00);
  endtask : load_map
endmodule : atp_host_model

// file: dv/adc_test_pattern_config_regs_test.sv
// self-checking bench for the test pattern and clock config slice
module adc_test_pattern_config_regs_test
  import atp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0]  reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [REG_W-1:0]  reg_rdata;
  logic              reg_rvalid;
  logic [1:0]        iface_mode;
  logic              sample_valid;
  logic [17:0]       chan_a_conv;
  logic [17:0]       chan_b_conv;
  logic [17:0]       chan_a_data;
  logic [17:0]       chan_b_data;
  logic              fuse_map_load;
  logic [1:0]        bit_map_sel;
  logic              dclk_en;
  logic              fc_src;
  logic              fc_div;
  logic              fc_en;
  logic              fc_str;
  int                n_mismatch;
  int                n_tests;
  logic [7:0]        ofs [8] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h18,
                                 8'h19, 8'h17, 8'h20};
  logic [7:0]        rv  [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
                                 8'h02, 8'h00, 8'h00};
  logic [7:0]        fv  [8] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h10,
                                 8'h93, 8'h00, 8'h00};

  atp_config_regs uut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .iface_mode(iface_mode), .sample_valid(sample_valid),
    .chan_a_conv(chan_a_conv), .chan_b_conv(chan_b_conv),
    .chan_a_data(chan_a_data), .chan_b_data(chan_b_data),
    .fuse_map_load(fuse_map_load), .bit_map_sel(bit_map_sel),
    .data_clock_input_buf_en(dclk_en), .frame_clock_source(fc_src),
    .frame_clock_divide(fc_div), .frame_clock_output_enable(fc_en),
    .frame_clock_stretch(fc_str)
  );

  atp_host_model host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host.rd_reg(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end else begin
      chk($sformatf("reg %0h", a), d, exp);
    end
  endtask : rd_chk

  task automatic smp(input logic [17:0] a, input logic [17:0] b);
    @(negedge clk);
    chan_a_conv = a;
    chan_b_conv = b;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask : smp

  initial begin
    logic [17:0] pv;
    logic [17:0] ca;
    logic [17:0] cb;
    logic [17:0] rexp;
    logic [2:0]  c;
    logic        ramp_on;
    rst_b = 1'b0;
    iface_mode = 2'h0;
    sample_valid = 1'b0;
    chan_a_conv = '0;
    chan_b_conv = '0;
    n_mismatch = 0;
    n_tests = 0;
    pv = 18'h2A5C3;
    ca = 18'h11111;
    cb = ~ca;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk("dclk_en", dclk_en, 1);
    chk("frame_clock_output_enable", fc_en, 1);
    for (int i = 0; i < 8; i++) rd_chk(ofs[i], rv[i]);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) host.wr_reg(ofs[i], 8'hFF);
    for (int i = 0; i < 8; i++) rd_chk(ofs[i], fv[i]);
    chk("fclk bits", {fc_src, fc_div, fc_en, fc_str}, 4'hF);
    host.wr_reg(DCLK_CTRL_OFS, 8'h00);
    chk("dclk_en off", dclk_en, 0);
    $display("test write_read done");
    host.wr_reg(PAT_LOW_OFS, pv[7:0]);
    host.wr_reg(PAT_MID_OFS, pv[15:8]);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        c = k[2:0];
        iface_mode = c[1:0];
        host.wr_reg(PAT_HIGH_OFS, s ? {c, 3'h0, pv[17:16]}
                                    : {3'h0, c, pv[17:16]});
        rexp = '0;
        for (int j = 0; j < 3; j++) begin
          ca = ca + 18'h00101;
          cb = ~ca;
          smp(ca, cb);
          ramp_on = (c == SEL_RAMP);
          chk("sel chan", s ? chan_a_data : chan_b_data,
              s ? ca : cb);
          chk("pattern", s ? chan_b_data : chan_a_data,
              ramp_on ? rexp : (c == SEL_CONSTANT) ? pv
                             : (s ? cb : ca));
          rexp = rexp + pv;
        end
      end
    end
    $display("test patterns done");
    // unit increment gives a full-width ramp
    host.wr_reg(PAT_LOW_OFS, 8'h01);
    host.wr_reg(PAT_MID_OFS, 8'h00);
    host.wr_reg(PAT_HIGH_OFS, {3'h0, SEL_RAMP, 2'h0});
    for (int j = 0; j < 3; j++) begin
      smp(ca, cb);
      chk("ramp unit", chan_a_data, j);
    end
    $display("test ramp_unit done");
    iface_mode = 2'h1;
    host.wr_reg(FUSE_LOAD_OFS, 8'h01);
    chk("no load", fuse_map_load, 0);
    host.wr_reg(FUSE_LOAD_OFS, 8'h00);
    for (int i = 0; i < 6 && fuse_map_load !== 1'b1; i++) @(negedge clk);
    chk("load pulse", fuse_map_load, 1);
    if (fuse_map_load !== 1'b1) begin
      stop_test();
    end
    chk("map sel", bit_map_sel, 2'h1);
    @(negedge clk);
    chk("pulse end", fuse_map_load, 0);
    chk("dclk_en", dclk_en, 1);
    for (int i = 0; i < 8; i++) rd_chk(ofs[i], rv[i]);
    host.wr_reg(DCLK_CTRL_OFS, 8'h10);
    $display("test fuse_load done");
    stop_test();
  end
endmodule : adc_test_pattern_config_regs_test
